// File: dv/dac_door_hw.sv
// Door hardware model: door contact and credential reader.
// Assumes the bench calls its tasks; pins change after a rising edge.
`timescale 1ns/1ps
module dac_door_hw (
	// Clock
	input wire logic hclk,
	// Door pins
	output logic door_open_pin,
	output logic cred_req_pin
);
	// ==========
	// Idle pins at time zero
	initial begin
		door_open_pin = 1'b0;
		cred_req_pin = 1'b0;
	end
	// Credential held long enough to pass the synchroniser
	task present;
		@(posedge hclk);
		cred_req_pin <= 1'b1;
		repeat (6) @(posedge hclk);
		cred_req_pin <= 1'b0;
		repeat (6) @(posedge hclk);
	endtask : present
	// Door contact, high while open
	task door(input logic v);
		@(posedge hclk);
		door_open_pin <= v;
	endtask : door
endmodule : dac_door_hw

// File: dv/dac_door_monitor.sv
// Port checker for the door controller.
// Assumes a bind onto dac_door; one clock, async active-low reset.
`timescale 1ns/1ps
module dac_door_monitor
	import dac_pkg::*;
(
	// Clock, reset and bus
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	// Door side
	input wire logic door_open_pin,
	input wire logic in_area_armed,
	input wire logic in_user_can_disarm,
	input wire logic out_area_armed,
	input wire logic out_user_can_disarm,
	input wire logic lock_release,
	input wire logic slave_lock_release,
	input wire logic [7:0] slave_door,
	input wire logic pre_alarm_out,
	input wire logic left_open_out,
	input wire logic left_open_tz,
	input wire logic in_area_disarm,
	input wire logic out_area_disarm
);
	// ==========
	// Index read tracking
	logic rd_id_q;
	logic rd_id_d;
	// Flag the address phase of an index read
	always_comb begin
		rd_id_d = hsel && hready && htrans == HTRANS_NONSEQ && !hwrite && haddr == 32'h0000_0000;
	end
	// Register the flag
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_id_q <= 1'b0;
		end else begin
			rd_id_q <= rd_id_d;
		end
	end
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// ==========
	// Properties
	property p_id; rd_id_q |-> hrdata >= 32'h0000_0001 && hrdata <= 32'h0000_00FA; endproperty
	a_id: assert property (p_id) else $error("index out of range");
	property p_sl_rise; $rose(lock_release) && slave_door != 8'h00 |-> ##[0:1] slave_lock_release; endproperty
	a_sl_rise: assert property (p_sl_rise) else $error("slave lock missed");
	property p_sl_follow; slave_lock_release |-> lock_release || $past(lock_release); endproperty
	a_sl_follow: assert property (p_sl_follow) else $error("slave lock alone");
	property p_in_dis; in_area_disarm |-> ($past(in_area_armed) && $past(in_user_can_disarm)) ##1 !in_area_disarm; endproperty
	a_in_dis: assert property (p_in_dis) else $error("bad inside disarm");
	property p_out_dis; out_area_disarm |-> ($past(out_area_armed) && $past(out_user_can_disarm)) ##1 !out_area_disarm;
	endproperty
	a_out_dis: assert property (p_out_dis) else $error("bad outside disarm");
	property p_pre; !door_open_pin [*8] |=> !pre_alarm_out; endproperty
	a_pre: assert property (p_pre) else $error("pre-alarm while closed");
	property p_left; !door_open_pin [*8] |=> !left_open_out; endproperty
	a_left: assert property (p_left) else $error("left-open while closed");
	property p_tz; left_open_tz |-> left_open_out; endproperty
	a_tz: assert property (p_tz) else $error("zone without alarm");
	// Main scenarios
	c_grant: cover property ($rose(lock_release));
	c_left: cover property ($rose(left_open_tz));
	c_dis: cover property (in_area_disarm);
endmodule : dac_door_monitor
bind dac_door dac_door_monitor mon (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata,
	.door_open_pin, .in_area_armed, .in_user_can_disarm, .out_area_armed, .out_user_can_disarm, .lock_release,
	.slave_lock_release, .slave_door, .pre_alarm_out, .left_open_out, .left_open_tz, .in_area_disarm,
	.out_area_disarm);

// File: dv/tb_dac_door.sv
// Bench for dac_door: AHB-Lite master tasks, door model, random and corner tests.
// Assumes the monitor is bound to the design.
`timescale 1ns/1ps
module tb_dac_door;
	import dac_pkg::*;
	// ==========
	// Signals
	logic hclk = '0, hresetn = '0, hsel = '0, hwrite = '0, cred_ok = '0, ilk_group_secure = '0, sched_active = '0;
	logic in_area_armed = '0, in_user_can_disarm = '0, out_area_armed = '0, out_user_can_disarm = '0;
	logic [31:0] haddr = '0, hwdata = '0, hrdata, r;
	logic [1:0] htrans = '0, sched_mode = '0, cred_mode, dis_seen;
	logic [2:0] hsize = 3'h2;
	logic [7:0] slave_door, v;
	logic hreadyout, hresp, door_open_pin, cred_req_pin, lock_release, slave_lock_release, pre_alarm_out;
	logic left_open_out, left_open_tz, in_area_disarm, out_area_disarm, irq;
	int miscompares = 0, checks_done = 0, cyc = 0, i;
	dac_door dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata,
		.hreadyout, .hresp, .door_open_pin, .cred_req_pin, .cred_ok, .ilk_group_secure, .in_area_armed,
		.in_user_can_disarm, .out_area_armed, .out_user_can_disarm, .sched_active, .sched_mode, .lock_release,
		.slave_lock_release, .slave_door, .pre_alarm_out, .left_open_out, .left_open_tz, .in_area_disarm,
		.out_area_disarm, .cred_mode, .irq);
	dac_door_hw hw (.hclk, .door_open_pin, .cred_req_pin);
	// Clock
	always #50 hclk = ~hclk;
	// Disarm pulses and cycle ceiling
	always @(posedge hclk) begin
		cyc++;
		if (in_area_disarm === 1'b1) dis_seen[0] = 1'b1;
		if (out_area_disarm === 1'b1) dis_seen[1] = 1'b1;
		if (cyc == 20000) begin
			miscompares++;
			summarize();
		end
	end
	// ==========
	// Tasks
	task chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected at %0t: %s got %h want %h", $time, m, seen, exp);
		end
	endtask : chk
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= HTRANS_NONSEQ;
		haddr <= {24'h000000, a};
		hwrite <= w;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		r = hrdata;
		repeat (2) @(posedge hclk);
	endtask : bus
	task setup(input logic [31:0] c, input logic [31:0] t);
		hresetn <= 1'b0;
		{cred_ok, ilk_group_secure} <= 2'h3;
		{in_area_armed, in_user_can_disarm, out_area_armed, out_user_can_disarm, sched_active} <= '0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		bus(1'b1, OFF_MASK, 32'h0000_001F);
		bus(1'b1, OFF_TIME, t);
		bus(1'b1, OFF_CFG, c);
	endtask : setup
	task grant;
		dis_seen = 2'h0;
		hw.present();
	endtask : grant
	task wl(input logic e);
		for (int k = 0; k < 20 && lock_release !== e; k++) @(posedge hclk);
		chk(32'(lock_release), 32'(e), "lock");
	endtask : wl
	function logic [31:0] rst_val(input int a);
		case (a)
			0: return {24'h000000, RST_DOOR};
			8: return RST_TIME;
			default: return '0;
		endcase
	endfunction : rst_val
	task summarize;
		$display("checks %0d miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : summarize
	// ==========
	// Tests
	initial begin
		void'($urandom(84850));
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		for (i = 0; i < 32; i += 4) begin
			bus(1'b0, 8'(i), '0);
			chk(r, rst_val(i), "reset value");
		end
		chk(32'(hresp), '0, "okay response");
		for (i = 0; i < 4; i++) begin
			v = 8'($urandom_range(250, 1));
			bus(1'b1, OFF_ID, {24'h000000, v});
			bus(1'b1, OFF_ID, 32'h0000_00FB);
			bus(1'b1, OFF_ID, '0);
			bus(1'b0, OFF_ID, '0);
			chk(r, {24'h000000, v}, "index");
		end
		for (i = 0; i < 4; i++) begin
			bus(1'b1, OFF_CFG, 32'(i));
			chk(32'(cred_mode), 32'(i), "mode");
		end
		sched_mode <= 2'($urandom);
		sched_active <= 1'b1;
		bus(1'b1, OFF_CFG, 32'h0040_0000);
		chk(32'(cred_mode), 32'(sched_mode), "sched mode");
		$display("test regs done");
		setup(32'h0006_0700, RST_TIME);
		{in_area_armed, in_user_can_disarm, out_area_armed, out_user_can_disarm} <= 4'hF;
		bus(1'b1, OFF_ID, 32'h0000_0003);
		grant();
		chk(32'(lock_release), 32'h1, "grant");
		chk(32'(slave_lock_release), 32'h1, "slave");
		chk(32'(slave_door), 32'h7, "slave index");
		chk(32'(dis_seen), 32'h3, "disarm");
		chk(32'(irq), 32'h1, "irq");
		bus(1'b1, OFF_IRQ, 32'h0000_001F);
		bus(1'b0, OFF_IRQ, '0);
		chk(r, '0, "irq clear");
		bus(1'b0, OFF_STAT, '0);
		chk(r, 32'h0000_000A, "status grant");
		$display("test grant done");
		setup(RST_CFG, 32'h002D_1E00);
		grant();
		wl(1'b0);
		setup(32'h0001_0000, RST_TIME);
		ilk_group_secure <= 1'b0;
		grant();
		wl(1'b0);
		bus(1'b0, OFF_IRQ, '0);
		chk(32'(r[IRQ_DENY_ILK]), 32'h1, "interlock");
		for (i = 0; i < 2; i++) begin
			setup(32'h1 << (17 + i), RST_TIME);
			in_area_armed <= (i == 0);
			out_area_armed <= (i == 1);
			grant();
			wl(1'b0);
			bus(1'b0, OFF_IRQ, '0);
			chk(32'(r[IRQ_DENY_AREA]), 32'h1, "area deny");
		end
		setup(32'h0000_0900, RST_TIME);
		bus(1'b1, OFF_ID, 32'h0000_0009);
		grant();
		chk(32'(slave_door), '0, "self slave");
		chk(32'(slave_lock_release), '0, "self lock");
		$display("test deny done");
		setup(32'h0008_0000, RST_TIME);
		sched_active <= 1'b1;
		wl(1'b1);
		sched_active <= 1'b0;
		wl(1'b0);
		// late unlock waits for a grant
		setup(32'h0018_0000, 32'h002D_1E00);
		sched_active <= 1'b1;
		repeat (10) @(posedge hclk);
		wl(1'b0);
		grant();
		wl(1'b1);
		$display("test schedule done");
		setup(RST_CFG, '0);
		hw.door(1'b1);
		for (i = 0; i < 20 && left_open_out !== 1'b1; i++) @(posedge hclk);
		chk(32'(left_open_out), 32'h1, "left open");
		chk(32'(left_open_tz), '0, "zone off");
		chk(32'(pre_alarm_out), '0, "pre off");
		bus(1'b0, OFF_STAT, '0);
		chk(r, 32'h0000_0021, "status open");
		bus(1'b1, OFF_CFG, 32'h0020_0000);
		chk(32'(left_open_tz), 32'h1, "zone on");
		bus(1'b1, OFF_MASK, '0);
		chk(32'(irq), '0, "masked");
		hw.door(1'b0);
		repeat (10) @(posedge hclk);
		bus(1'b1, OFF_IRQ, 32'h0000_001F);
		bus(1'b0, OFF_IRQ, '0);
		chk(r, '0, "left cleared");
		$display("test open done");
		summarize();
	end
endmodule : tb_dac_door

// File: rtl/dac_door.sv
// Single-door access controller with AHB-Lite register slave.
// Assumes external door sensor/credential pins and area/schedule status inputs.
`timescale 1ns/1ps
module dac_door (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Door pins (asynchronous)
	input wire logic door_open_pin,
	input wire logic cred_req_pin,
	// Decision inputs from system logic (same clock)
	input wire logic cred_ok,
	input wire logic ilk_group_secure,
	input wire logic in_area_armed,
	input wire logic in_user_can_disarm,
	input wire logic out_area_armed,
	input wire logic out_user_can_disarm,
	input wire logic sched_active,
	input wire logic [1:0] sched_mode,
	// Door outputs
	output logic lock_release,
	output logic slave_lock_release,
	output logic [7:0] slave_door,
	output logic pre_alarm_out,
	output logic left_open_out,
	output logic left_open_tz,
	output logic in_area_disarm,
	output logic out_area_disarm,
	output logic [1:0] cred_mode,
	output logic irq
);
	import dac_pkg::*;

	// ==========================================
	// Input synchronisers
	logic [2:0] open_sy_q, open_sy_d;
	logic [2:0] req_sy_q, req_sy_d;
	logic door_open_q, door_open_d;
	logic req_q, req_d;
	logic req_ev;

	// Three-stage sync, change taken when stages two and three agree
	always_comb begin
		open_sy_d = {open_sy_q[1:0], door_open_pin};
		req_sy_d = {req_sy_q[1:0], cred_req_pin};
		door_open_d = (open_sy_q[2] == open_sy_q[1]) ? open_sy_q[2] : door_open_q;
		req_d = (req_sy_q[2] == req_sy_q[1]) ? req_sy_q[2] : req_q;
	end
	assign req_ev = req_d & ~req_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			open_sy_q <= 3'h0;
			req_sy_q <= 3'h0;
			door_open_q <= 1'b0;
			req_q <= 1'b0;
		end else begin
			open_sy_q <= open_sy_d;
			req_sy_q <= req_sy_d;
			door_open_q <= door_open_d;
			req_q <= req_d;
		end
	end

	// ==========================================
	// Register file and AHB-Lite slave
	logic [7:0] door_q, door_d;
	logic [31:0] cfg_q, cfg_d;
	logic [31:0] time_q, time_d;
	logic [31:0] pulse_q, pulse_d;
	logic [IRQ_W-1:0] irq_q, irq_d;
	logic [IRQ_W-1:0] mask_q, mask_d;
	logic [IRQ_W-1:0] ev;
	logic wr_pend_q, wr_pend_d;
	logic [7:0] wr_addr_q, wr_addr_d;
	logic [31:0] hrdata_q, hrdata_d;
	logic addr_ok;
	logic [31:0] stat;

	assign addr_ok = hsel & hready & (htrans == HTRANS_NONSEQ);
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_q;

	// Read mux
	function automatic logic [31:0] rd_mux(input logic [7:0] a, input logic [31:0] c, input logic [31:0] t,
		input logic [31:0] p, input logic [31:0] s, input logic [IRQ_W-1:0] i,
		input logic [IRQ_W-1:0] m, input logic [7:0] d);
		logic [31:0] r;
		r = 32'h0000_0000;
		unique case (a)
			OFF_ID: r = {24'h000000, d};
			OFF_CFG: r = c;
			OFF_TIME: r = t;
			OFF_PULSE: r = p;
			OFF_STAT: r = s;
			OFF_IRQ: r = {{(32 - IRQ_W){1'b0}}, i};
			OFF_MASK: r = {{(32 - IRQ_W){1'b0}}, m};
			default: r = 32'h0000_0000;
		endcase
		return r;
	endfunction : rd_mux

	// Bus and register next state
	always_comb begin
		door_d = door_q;
		cfg_d = cfg_q;
		time_d = time_q;
		pulse_d = pulse_q;
		mask_d = mask_q;
		irq_d = irq_q;
		hrdata_d = hrdata_q;
		wr_pend_d = addr_ok & hwrite;
		wr_addr_d = addr_ok ? haddr[7:0] : wr_addr_q;
		if (addr_ok && !hwrite) begin
			hrdata_d = rd_mux(haddr[7:0], cfg_q, time_q, pulse_q, stat, irq_q, mask_q, door_q);
		end
		if (wr_pend_q) begin
			unique case (wr_addr_q)
				OFF_ID: begin
					if (hwdata[7:0] >= DOOR_MIN && hwdata[7:0] <= DOOR_MAX) begin
						door_d = hwdata[7:0];
					end
				end
				OFF_CFG: cfg_d = hwdata;
				OFF_TIME: time_d = hwdata;
				OFF_PULSE: pulse_d = hwdata;
				OFF_IRQ: irq_d = irq_q & ~hwdata[IRQ_W-1:0];
				OFF_MASK: mask_d = hwdata[IRQ_W-1:0];
				default: ;
			endcase
		end
		// Set wins over clear
		irq_d = irq_d | ev;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			door_q <= RST_DOOR;
			cfg_q <= RST_CFG;
			time_q <= RST_TIME;
			pulse_q <= RST_PULSE;
			irq_q <= '0;
			mask_q <= '0;
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
			hrdata_q <= 32'h0000_0000;
		end else begin
			door_q <= door_d;
			cfg_q <= cfg_d;
			time_q <= time_d;
			pulse_q <= pulse_d;
			irq_q <= irq_d;
			mask_q <= mask_d;
			wr_pend_q <= wr_pend_d;
			wr_addr_q <= wr_addr_d;
			hrdata_q <= hrdata_d;
		end
	end
	assign irq = |(irq_q & mask_q);

	// ==========================================
	// Configuration fields
	logic [7:0] t_unlock, t_pre, t_max, p_on, p_off;
	logic ilk_en, in_en, out_en, sch_en, late_en, lo_tz_en;
	assign t_unlock = time_q[TIME_UNLOCK_LSB +: 8];
	assign t_pre = time_q[TIME_PRE_LSB +: 8];
	assign t_max = time_q[TIME_MAX_LSB +: 8];
	assign p_on = pulse_q[7:0];
	assign p_off = pulse_q[15:8];
	assign ilk_en = cfg_q[CFG_ILK_EN];
	assign in_en = cfg_q[CFG_IN_EN];
	assign out_en = cfg_q[CFG_OUT_EN];
	assign sch_en = cfg_q[CFG_SCH_EN];
	assign late_en = cfg_q[CFG_LATE];
	assign lo_tz_en = cfg_q[CFG_LO_TZ_EN];

	assign cred_mode = cfg_q[CFG_SCHMODE_EN] ? sched_mode : cfg_q[CFG_MODE_LSB +: 2];

	// ==========================================
	// Second and 100 ms ticks
	logic [23:0] sec_cnt_q, sec_cnt_d;
	logic [23:0] dec_cnt_q, dec_cnt_d;
	logic sec_tick, dec_tick;

	assign sec_tick = (sec_cnt_q == 24'(SEC_CYCLES - 1));
	assign dec_tick = (dec_cnt_q == 24'(PULSE_UNIT_CYCLES - 1));
	always_comb begin
		sec_cnt_d = sec_tick ? 24'h000000 : sec_cnt_q + 24'h000001;
		dec_cnt_d = dec_tick ? 24'h000000 : dec_cnt_q + 24'h000001;
	end

	// ==========================================
	// Access decision and door state
	logic deny_ilk, deny_area, grant;
	logic [7:0] unl_q, unl_d;
	logic unl_act_q, unl_act_d;
	logic [7:0] open_q, open_d;
	logic late_ok_q, late_ok_d;
	logic sch_prev_q, sch_prev_d;
	logic pre_q, pre_d, left_q, left_d;
	logic in_dis_q, in_dis_d, out_dis_q, out_dis_d;
	logic lock_q, lock_d;
	logic sch_unlock;

	assign deny_ilk = req_ev & ilk_en & ~ilk_group_secure;
	assign deny_area = req_ev & ~deny_ilk & cred_ok &
		((in_en & in_area_armed & ~in_user_can_disarm) | (out_en & out_area_armed & ~out_user_can_disarm));
	assign grant = req_ev & cred_ok & ~deny_ilk & ~deny_area;

	assign sch_unlock = sch_en & sched_active & (~late_en | late_ok_q);

	// Timers and flags next state
	always_comb begin
		unl_d = unl_q;
		unl_act_d = unl_act_q;
		open_d = open_q;
		pre_d = pre_q;
		left_d = left_q;
		sch_prev_d = sch_en & sched_active;
		late_ok_d = late_ok_q;
		// Late arm cleared when a schedule interval starts
		if (!sch_prev_q && sch_en && sched_active) begin
			late_ok_d = 1'b0;
		end
		if (grant) begin
			late_ok_d = 1'b1;
		end
		if (grant) begin
			unl_d = 8'h00;
			unl_act_d = (t_unlock != 8'h00);
		end else if (unl_act_q && sec_tick) begin
			unl_d = unl_q + 8'h01;
			if (unl_q + 8'h01 >= t_unlock) begin
				unl_act_d = 1'b0;
			end
		end
		if (!door_open_q) begin
			open_d = 8'h00;
			pre_d = 1'b0;
			left_d = 1'b0;
		end else if (sec_tick && open_q != 8'hFF) begin
			open_d = open_q + 8'h01;
		end
		if (door_open_q && t_pre != 8'h00 && open_q >= t_pre) begin
			pre_d = 1'b1;
		end
		if (door_open_q && open_q >= t_max) begin
			left_d = 1'b1;
		end
		in_dis_d = grant & in_en & in_area_armed;
		out_dis_d = grant & out_en & out_area_armed;
		lock_d = unl_act_d | sch_unlock;
	end

	// Events to interrupt status
	assign ev = {left_d & ~left_q, pre_d & ~pre_q, deny_area, deny_ilk, grant};

	// ==========================================
	// Pre-alarm pulsing
	logic [7:0] pcnt_q, pcnt_d;
	logic phase_q, phase_d;
	logic pulse_en;

	// pulse only if both times nonzero
	assign pulse_en = (p_on != 8'h00) && (p_off != 8'h00);
	always_comb begin
		pcnt_d = pcnt_q;
		phase_d = phase_q;
		if (!pre_q || !pulse_en) begin
			pcnt_d = 8'h00;
			phase_d = 1'b1;
		end else if (dec_tick) begin
			if (pcnt_q + 8'h01 >= (phase_q ? p_on : p_off)) begin
				pcnt_d = 8'h00;
				phase_d = ~phase_q;
			end else begin
				pcnt_d = pcnt_q + 8'h01;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sec_cnt_q <= 24'h000000;
			dec_cnt_q <= 24'h000000;
			unl_q <= 8'h00;
			unl_act_q <= 1'b0;
			open_q <= 8'h00;
			late_ok_q <= 1'b0;
			sch_prev_q <= 1'b0;
			pre_q <= 1'b0;
			left_q <= 1'b0;
			in_dis_q <= 1'b0;
			out_dis_q <= 1'b0;
			lock_q <= 1'b0;
			pcnt_q <= 8'h00;
			phase_q <= 1'b1;
		end else begin
			sec_cnt_q <= sec_cnt_d;
			dec_cnt_q <= dec_cnt_d;
			unl_q <= unl_d;
			unl_act_q <= unl_act_d;
			open_q <= open_d;
			late_ok_q <= late_ok_d;
			sch_prev_q <= sch_prev_d;
			pre_q <= pre_d;
			left_q <= left_d;
			in_dis_q <= in_dis_d;
			out_dis_q <= out_dis_d;
			lock_q <= lock_d;
			pcnt_q <= pcnt_d;
			phase_q <= phase_d;
		end
	end

	// ==========================================
	// Outputs
	logic slave_valid;
	// slave follows unless self or none
	assign slave_valid = (cfg_q[CFG_SLAVE_LSB +: 8] != 8'h00) && (cfg_q[CFG_SLAVE_LSB +: 8] != door_q);
	assign slave_door = slave_valid ? cfg_q[CFG_SLAVE_LSB +: 8] : 8'h00;
	assign slave_lock_release = slave_valid & lock_q;
	assign lock_release = lock_q;
	assign pre_alarm_out = pre_q & (~pulse_en | phase_q);
	assign left_open_out = left_q;
	assign left_open_tz = left_q & lo_tz_en;
	assign in_area_disarm = in_dis_q;
	assign out_area_disarm = out_dis_q;
	assign stat = {24'h000000, 1'b0, in_dis_q, left_q, pre_q, unl_act_q, sch_unlock, lock_q, door_open_q};
endmodule : dac_door

// File: rtl/dac_pkg.sv
// Door access controller package: register map, field layout, reset values, timing.
// Assumes a 10 MHz hclk and a 32-bit AHB-Lite register bus.
package dac_pkg;
	// ==========================================
	// Clock and timing
	localparam int unsigned CLK_HZ = 10_000_000;
	localparam int unsigned SEC_MS = 1000;
	localparam int unsigned PULSE_UNIT_MS = 100;
	// Cycles per whole second and per 100 ms step; both fit the 24-bit tick counters
	localparam int unsigned SEC_CYCLES = CLK_HZ / 1000 * SEC_MS;
	localparam int unsigned PULSE_UNIT_CYCLES = CLK_HZ / 1000 * PULSE_UNIT_MS;
	// ==========================================
	// Register offsets (byte addresses)
	localparam logic [7:0] OFF_ID = 8'h00;
	localparam logic [7:0] OFF_CFG = 8'h04;
	localparam logic [7:0] OFF_TIME = 8'h08;
	localparam logic [7:0] OFF_PULSE = 8'h0C;
	localparam logic [7:0] OFF_STAT = 8'h10;
	localparam logic [7:0] OFF_IRQ = 8'h14;
	localparam logic [7:0] OFF_MASK = 8'h18;
	// ==========================================
	// Door index limits
	localparam logic [7:0] DOOR_MIN = 8'h01;
	localparam logic [7:0] DOOR_MAX = 8'hFA;
	// Field positions inside CFG
	localparam int CFG_MODE_LSB = 0;
	localparam int CFG_SLAVE_LSB = 8;
	localparam int CFG_ILK_EN = 16;
	localparam int CFG_IN_EN = 17;
	localparam int CFG_OUT_EN = 18;
	localparam int CFG_SCH_EN = 19;
	localparam int CFG_LATE = 20;
	localparam int CFG_LO_TZ_EN = 21;
	localparam int CFG_SCHMODE_EN = 22;
	localparam int CFG_SCHMODE_LSB = 24;
	// Field positions inside TIME
	localparam int TIME_UNLOCK_LSB = 0;
	localparam int TIME_PRE_LSB = 8;
	localparam int TIME_MAX_LSB = 16;
	// Interrupt status bits
	localparam int IRQ_GRANT = 0;
	localparam int IRQ_DENY_ILK = 1;
	localparam int IRQ_DENY_AREA = 2;
	localparam int IRQ_PRE = 3;
	localparam int IRQ_LEFT = 4;
	localparam int IRQ_W = 5;
	// ==========================================
	// Reset values
	localparam logic [7:0] RST_DOOR = 8'h01;
	localparam logic [31:0] RST_CFG = 32'h0000_0000;
	localparam logic [7:0] RST_UNLOCK = 8'h05;
	localparam logic [7:0] RST_PRE = 8'h1E;
	localparam logic [7:0] RST_MAX = 8'h2D;
	localparam logic [31:0] RST_TIME = {8'h00, RST_MAX, RST_PRE, RST_UNLOCK};
	localparam logic [31:0] RST_PULSE = 32'h0000_0000;
	// Credential modes
	typedef enum logic [1:0] {
		DAC_CARD = 2'h0,
		DAC_CARD_PIN = 2'h1,
		DAC_CARD_OR_PIN = 2'h2,
		DAC_PIN = 2'h3
	} dac_mode_t;
	// AHB
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage : dac_pkg
